// ---- logic/crc_result_port_map.svh ----
/*
 Register offsets, field positions, reset values and constants of the CRC engine.
 Assumes it is included by the engine module, the monitor and the bench by its bare name.
*/
// Notes on behaviour
// - With poly_select at 0 the engine folds bytes into a 32-bit result with polynomial 0x04C11DB7.
// - With poly_select at 1 the engine folds bytes into a 16-bit result with polynomial 0x1021.
// - Writing 1 to result_init loads the whole result with the preset picked by init_value_select.
// - With init_value_select at 0 an init write clears every result bit.
// - With init_value_select at 1 an init write sets every result bit to one.
// - The two-bit result_byte_pointer picks the byte that the next port access reaches and steps after every read and write of the port.
// - In 32-bit mode pointer 00, 01, 10, 11 reach result bits 7-0, 15-8, 23-16, 31-24.
// - In 16-bit mode pointer 00 reaches bits 7-0, 01 bits 15-8 and 10 bits 7-0 again.
// - Every byte written to the data input port is folded into the running result.
// - A read of the result byte port returns the selected byte and a write replaces that byte.
// - Each byte is XORed into the top byte of the accumulator, then eight shift steps XOR the polynomial when the shifted-out MSB was set.
// - With auto_flash_enable set and sector_count nonzero, a control write CRCs sector_count 512-byte flash sectors from start_sector while stalling the core.
// - The result holds until reinitialised, overwritten through the port, or changed by more input bytes or by an automatic flash walk.
`ifndef CRC_RESULT_PORT_MAP_SVH
`define CRC_RESULT_PORT_MAP_SVH

// register addresses
`define CRC_ADDR_RESULT_PORT 8'h91
`define CRC_ADDR_CONTROL     8'h92
`define CRC_ADDR_DATA_INPUT  8'h93
`define CRC_ADDR_AUTO        8'h96
`define CRC_ADDR_COUNT       8'h97

// control register fields
`define CRC_CTL_POLY_BIT     4
`define CRC_CTL_INIT_BIT     3
`define CRC_CTL_VAL_BIT      2
`define CRC_CTL_PTR_HI       1
`define CRC_CTL_PTR_LO       0

// automatic control register fields
`define CRC_AUTO_EN_BIT      7
`define CRC_AUTO_DONE_BIT    6
`define CRC_AUTO_ST_HI       5

// values
`define CRC_POLY32           32'h04C1_1DB7
`define CRC_POLY16           16'h1021
`define CRC_PRESET_ZERO      32'h0000_0000
`define CRC_PRESET_ONES      32'hFFFF_FFFF
`define CRC_RESET_BYTE       8'h00
`define CRC_SECTOR_SHIFT     9
`define CRC_FLASH_AW         15

`endif

// ---- logic/crc_pkg.sv ----
/*
 Types shared by the CRC engine.
 Assumes nothing of its surroundings.
*/
package crc_pkg;
	// automatic flash walk states
	typedef enum logic [1:0] {
		CRC_IDLE,
		CRC_WAIT,
		CRC_FOLD
	} crc_state_type;
endpackage

// ---- logic/crc_result_port.sv ----
/*
 Byte-wide CRC engine behind a special function register port, with an
 automatic flash walk. Assumes the register strobes come from the core on the
 same clock and that flash returns data the cycle after a read pulse.
*/
`timescale 1ns/1ps
`include "crc_result_port_map.svh"

module crc_result_port (
	// clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_i,
	// register port
	input  wire logic [7:0]               sfr_addr_i,
	input  wire logic                     sfr_wr_i,
	input  wire logic                     sfr_rd_i,
	input  wire logic [7:0]               sfr_wdata_i,
	output logic      [7:0]               sfr_rdata_o,
	// flash read port
	output logic                          flash_rd_o,
	output logic      [`CRC_FLASH_AW-1:0] flash_addr_o,
	input  wire logic [7:0]               flash_data_i,
	// processor stall
	output logic                          cpu_stall_o
);

	// fold one byte into the running result
	function automatic logic [31:0] crc_fold(input logic [31:0] acc, input logic [7:0] din,
		input logic sel16);
		logic [31:0] a;
		logic [15:0] b;
		a = acc;
		b = acc[15:0];
		if (sel16) begin
			b = b ^ {din, 8'h00};
			for (int i = 0; i < 8; i++) begin
				if (b[15]) begin
					b = {b[14:0], 1'b0} ^ `CRC_POLY16;
				end else begin
					b = {b[14:0], 1'b0};
				end
			end
			a = {acc[31:16], b};
		end else begin
			a = a ^ {din, 24'h00_0000};
			for (int i = 0; i < 8; i++) begin
				if (a[31]) begin
					a = {a[30:0], 1'b0} ^ `CRC_POLY32;
				end else begin
					a = {a[30:0], 1'b0};
				end
			end
		end
		return a;
	endfunction

	// byte index reached by the pointer
	function automatic logic [1:0] crc_byte_idx(input logic [1:0] ptr, input logic sel16);
		return sel16 ? {1'b0, ptr[0]} : ptr;
	endfunction

	// write strobe aimed at one register address
	function automatic logic crc_wr_hit(input logic wr, input logic [7:0] addr,
		input logic [7:0] target);
		return wr && (addr == target);
	endfunction

	logic                     sel_reg,    sel_next;
	logic                     val_reg,    val_next;
	logic [1:0]               ptr_reg,    ptr_next;
	logic [31:0]              result_reg, result_next;
	logic [7:0]               din_reg,    din_next;
	logic                     auto_reg,   auto_next;
	logic [5:0]               start_reg,  start_next;
	logic [5:0]               count_reg,  count_next;
	logic [7:0]               rdata_reg,  rdata_next;
	crc_pkg::crc_state_type   state_reg,  state_next;
	logic [`CRC_FLASH_AW-1:0] addr_reg,   addr_next;
	logic [15:0]              left_reg,   left_next;
	logic                     rd_reg,     rd_next;
	logic                     stall_reg,  stall_next;
	logic [1:0]               idx;
	logic                     wr_res;
	logic                     wr_ctl;
	logic                     wr_din;
	logic                     wr_auto;
	logic                     wr_cnt;

	// byte index and one-cycle write strobes per register
	assign idx     = crc_byte_idx(ptr_reg, sel_reg);
	assign wr_res  = crc_wr_hit(sfr_wr_i, sfr_addr_i, `CRC_ADDR_RESULT_PORT);
	assign wr_ctl  = crc_wr_hit(sfr_wr_i, sfr_addr_i, `CRC_ADDR_CONTROL);
	assign wr_din  = crc_wr_hit(sfr_wr_i, sfr_addr_i, `CRC_ADDR_DATA_INPUT);
	assign wr_auto = crc_wr_hit(sfr_wr_i, sfr_addr_i, `CRC_ADDR_AUTO);
	assign wr_cnt  = crc_wr_hit(sfr_wr_i, sfr_addr_i, `CRC_ADDR_COUNT);

	// register port, result and automatic walk next values
	always_comb begin
		sel_next    = sel_reg;
		val_next    = val_reg;
		ptr_next    = ptr_reg;
		result_next = result_reg;
		din_next    = din_reg;
		auto_next   = auto_reg;
		start_next  = start_reg;
		count_next  = count_reg;
		rdata_next  = rdata_reg;
		state_next  = state_reg;
		addr_next   = addr_reg;
		left_next   = left_reg;
		rd_next     = 1'b0;
		stall_next  = stall_reg;
		// reads
		if (sfr_rd_i) begin
			case (sfr_addr_i)
				`CRC_ADDR_RESULT_PORT: begin
					rdata_next = result_reg[8*idx +: 8];
					ptr_next   = ptr_reg + 2'd1;
				end
				`CRC_ADDR_CONTROL:    rdata_next = {3'b000, sel_reg, 1'b0, val_reg, ptr_reg};
				`CRC_ADDR_DATA_INPUT: rdata_next = din_reg;
				`CRC_ADDR_AUTO:       rdata_next = {auto_reg, ~stall_reg, start_reg};
				`CRC_ADDR_COUNT:      rdata_next = {2'b00, count_reg};
				default:              rdata_next = `CRC_RESET_BYTE;
			endcase
		end
		// writes
		if (wr_res) begin
			result_next[8*idx +: 8] = sfr_wdata_i;
			ptr_next                = ptr_reg + 2'd1;
		end
		if (wr_ctl) begin
			sel_next = sfr_wdata_i[`CRC_CTL_POLY_BIT];
			val_next = sfr_wdata_i[`CRC_CTL_VAL_BIT];
			ptr_next = sfr_wdata_i[`CRC_CTL_PTR_HI:`CRC_CTL_PTR_LO];
			if (sfr_wdata_i[`CRC_CTL_INIT_BIT]) begin
				result_next = sfr_wdata_i[`CRC_CTL_VAL_BIT] ? `CRC_PRESET_ONES
				                                             : `CRC_PRESET_ZERO;
			end
		end
		if (wr_din) begin
			din_next    = sfr_wdata_i;
			result_next = crc_fold(result_reg, sfr_wdata_i, sel_reg);
		end
		if (wr_auto) begin
			auto_next  = sfr_wdata_i[`CRC_AUTO_EN_BIT];
			start_next = sfr_wdata_i[`CRC_AUTO_ST_HI:0];
		end
		if (wr_cnt) begin
			count_next = sfr_wdata_i[5:0];
		end
		// automatic flash walk; the core is stalled so no port access overlaps it
		case (state_reg)
			crc_pkg::CRC_IDLE: begin
				if (wr_ctl && auto_reg && count_reg != 6'd0) begin
					addr_next  = `CRC_FLASH_AW'({start_reg, 9'd0});
					left_next  = 16'({count_reg, 9'd0});
					rd_next    = 1'b1;
					stall_next = 1'b1;
					state_next = crc_pkg::CRC_WAIT;
				end
			end
			// flash answers one cycle after the pulse, so the fold waits one edge
			crc_pkg::CRC_WAIT: state_next = crc_pkg::CRC_FOLD;
			crc_pkg::CRC_FOLD: begin
				result_next = crc_fold(result_reg, flash_data_i, sel_reg);
				left_next   = left_reg - 16'd1;
				if (left_reg > 16'd1) begin
					addr_next  = addr_reg + `CRC_FLASH_AW'd1;
					rd_next    = 1'b1;
					state_next = crc_pkg::CRC_WAIT;
				end else begin
					stall_next = 1'b0;
					state_next = crc_pkg::CRC_IDLE;
				end
			end
			default: begin
				stall_next = 1'b0;
				state_next = crc_pkg::CRC_IDLE;
			end
		endcase
	end

	// state registers
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sel_reg    <= 1'b0;
			val_reg    <= 1'b0;
			ptr_reg    <= 2'd0;
			result_reg <= `CRC_PRESET_ZERO;
			din_reg    <= `CRC_RESET_BYTE;
			auto_reg   <= 1'b0;
			start_reg  <= 6'd0;
			count_reg  <= 6'd0;
			rdata_reg  <= `CRC_RESET_BYTE;
			state_reg  <= crc_pkg::CRC_IDLE;
			addr_reg   <= '0;
			left_reg   <= 16'd0;
			rd_reg     <= 1'b0;
			stall_reg  <= 1'b0;
		end else begin
			sel_reg    <= sel_next;
			val_reg    <= val_next;
			ptr_reg    <= ptr_next;
			result_reg <= result_next;
			din_reg    <= din_next;
			auto_reg   <= auto_next;
			start_reg  <= start_next;
			count_reg  <= count_next;
			rdata_reg  <= rdata_next;
			state_reg  <= state_next;
			addr_reg   <= addr_next;
			left_reg   <= left_next;
			rd_reg     <= rd_next;
			stall_reg  <= stall_next;
		end
	end

	// outputs straight from flops
	assign sfr_rdata_o  = rdata_reg;
	assign flash_rd_o   = rd_reg;
	assign flash_addr_o = addr_reg;
	assign cpu_stall_o  = stall_reg;

endmodule

// ---- dv/crc_result_port_monitor.sv ----
/* port timing checks for the crc engine.
 assumes binding to crc_result_port, one clock domain. */
`timescale 1ns/1ps
`include "crc_result_port_map.svh"
module crc_result_port_monitor (
	input wire logic                     core_clk_i,
	input wire logic                     rst_i,
	input wire logic [7:0]               sfr_addr_i,
	input wire logic                     sfr_wr_i,
	input wire logic                     sfr_rd_i,
	input wire logic [7:0]               sfr_wdata_i,
	input wire logic [7:0]               sfr_rdata_o,
	input wire logic                     flash_rd_o,
	input wire logic [`CRC_FLASH_AW-1:0] flash_addr_o,
	input wire logic                     cpu_stall_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// control write with init, then a result read
	sequence s_init(v);
		sfr_wr_i && sfr_addr_i == 8'h92 && sfr_wdata_i[3] && sfr_wdata_i[2] == v;
	endsequence
	sequence s_port_rd;
		sfr_rd_i && sfr_addr_i == 8'h91 && !cpu_stall_o;
	endsequence
	a_init_zero: assert property (s_init(1'b0) ##1 s_port_rd |=> sfr_rdata_o == 8'h00)
		else $error("init to zeros not seen");
	a_init_ones: assert property (s_init(1'b1) ##1 s_port_rd |=> sfr_rdata_o == 8'hFF)
		else $error("init to ones not seen");
	a_pointer_step: assert property (sfr_wr_i && sfr_addr_i == 8'h92 ##1 s_port_rd ##1
		(sfr_rd_i && sfr_addr_i == 8'h92) |=> sfr_rdata_o[1:0] == $past(sfr_wdata_i[1:0], 3) + 2'd1)
		else $error("pointer did not step");
	a_ctl_init_reads: assert property (sfr_rd_i && sfr_addr_i == 8'h92 |=>
		sfr_rdata_o[7:5] == 3'b000 && !sfr_rdata_o[3]) else $error("control read wrong");
	a_stall_cause: assert property ($rose(cpu_stall_o) |->
		$past(sfr_wr_i) && $past(sfr_addr_i) == 8'h92 && flash_rd_o) else $error("stray stall");
	a_flash_in_stall: assert property (flash_rd_o |-> cpu_stall_o)
		else $error("flash read outside stall");
	a_flash_pulse: assert property (flash_rd_o |=> !flash_rd_o ##1 flash_rd_o || !cpu_stall_o)
		else $error("flash pulse spacing wrong");
	a_addr_ascend: assert property (flash_rd_o ##2 flash_rd_o |->
		flash_addr_o == $past(flash_addr_o, 2) + 1'b1) else $error("flash address not ascending");
endmodule
bind crc_result_port crc_result_port_monitor i_crc_result_port_monitor (.core_clk_i(core_clk_i),
	.rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
	.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .flash_rd_o(flash_rd_o),
	.flash_addr_o(flash_addr_o), .cpu_stall_o(cpu_stall_o));

// ---- dv/tb_crc_result_port.sv ----
/* self-checking bench for the crc engine.
 assumes the engine alone; flash is served by the bench. */
`timescale 1ns/1ps
`include "crc_result_port_map.svh"
module tb_crc_result_port;
	logic        core_clk_i, rst_i, sfr_wr_i, sfr_rd_i, flash_rd_o, cpu_stall_o;
	logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, flash_data_i, rv;
	logic [14:0] flash_addr_o;
	logic [31:0] m;
	int          fail_count, checked;
	crc_result_port i_crc_result_port (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .flash_rd_o(flash_rd_o),
		.flash_addr_o(flash_addr_o), .flash_data_i(flash_data_i), .cpu_stall_o(cpu_stall_o));
	// clock
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	function automatic logic [7:0] fl(logic [14:0] a);
		return a[7:0] ^ {1'b0, a[14:8]};
	endfunction
	// bench model of one byte fold
	function automatic logic [31:0] fold(logic [31:0] a, logic [7:0] b, logic s);
		if (s) a[15:8] ^= b;
		else a[31:24] ^= b;
		repeat (8) begin
			if (s) a[15:0] = {a[14:0], 1'b0} ^ (a[15] ? `CRC_POLY16 : 16'h0000);
			else a = {a[30:0], 1'b0} ^ (a[31] ? `CRC_POLY32 : 32'h0000_0000);
		end
		return a;
	endfunction
	// flash answers with a byte derived from its address
	always @(negedge core_clk_i) flash_data_i <= fl(flash_addr_o);
	task chk(string n, logic [15:0] e, logic [15:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// one access per cycle; strobes stay up for a following access
	task acc(logic w, logic [7:0] a, logic [7:0] d);
		{sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = {w, !w, a, d};
		@(negedge core_clk_i);
		rv = sfr_rdata_o;
	endtask
	task idle();
		{sfr_wr_i, sfr_rd_i} = 2'b00;
		@(negedge core_clk_i);
	endtask
	task rres(logic [7:0] c);
		if (c[3]) m = c[2] ? 32'hFFFF_FFFF : 32'h0000_0000;
		acc(1'b1, 8'h92, c);
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, 8'h91, 8'h00);
			chk("result byte", {8'h00, c[4] ? m[8*(i%2)+:8] : m[8*i+:8]}, {8'h00, rv});
		end
		idle();
	endtask
	task t_reset();
		acc(1'b0, 8'h92, 8'h00);
		chk("control", 16'h0000, {8'h00, rv});
		acc(1'b0, 8'h93, 8'h00);
		chk("data input", 16'h0000, {8'h00, rv});
		m = 32'h0000_0000; // result clears in reset
		rres(8'h00);
	endtask
	task t_fold(logic s, logic [7:0] c);
		rres(c);
		for (int i = 0; i < 8; i++) begin
			acc(1'b1, 8'h93, 8'h31 + 8'(i));
			m = fold(m, 8'h31 + 8'(i), s);
		end
		idle();
		rres({3'b000, s, 4'h0});
	endtask
	task t_port();
		acc(1'b1, 8'h92, 8'h02);
		acc(1'b1, 8'h91, 8'hA5);
		acc(1'b1, 8'h92, 8'h02);
		acc(1'b0, 8'h91, 8'h00);
		chk("written byte", 16'h00A5, {8'h00, rv});
		acc(1'b0, 8'h92, 8'h00);
		chk("pointer", 16'h0003, {14'h0, rv[1:0]});
		idle();
	endtask
	task t_auto();
		int n;
		acc(1'b1, 8'h96, 8'h81);
		acc(1'b1, 8'h97, 8'h01);
		acc(1'b1, 8'h92, 8'h18);
		idle(); // no access while the walk runs
		chk("walk start", 16'h0200, {1'b0, flash_addr_o});
		m = 32'h0000_0000;
		for (int a = 512; a < 1024; a++) m = fold(m, fl(15'(a)), 1'b1);
		// one stalled cycle has passed already during the idle call
		for (n = 1; cpu_stall_o === 1'b1 && n < 3000; n++) @(negedge core_clk_i);
		chk("walk cycles", 16'd1024, 16'(n));
		acc(1'b0, 8'h96, 8'h00);
		chk("auto done", 16'h00C1, {8'h00, rv});
		acc(1'b0, 8'h97, 8'h00);
		chk("sector count", 16'h0001, {8'h00, rv});
		acc(1'b1, 8'h96, 8'h00);
		rres(8'h10);
	endtask
	task conclude();
		$display("checks %0d failures %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (6000) @(posedge core_clk_i);
		fail_count++;
		conclude();
	end
	initial begin
		{rst_i, sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = {3'b100, 16'h0};
		repeat (10) @(negedge core_clk_i);
		rst_i = 1'b0;
		t_reset();
		t_fold(1'b1, 8'h18);
		t_fold(1'b0, 8'h0C);
		rres(8'h08);
		t_port();
		t_auto();
		conclude();
	end
endmodule
